// file: hdl/bec_defines.svh
/*
 buffer event block constants: register offsets, identifiers, field positions,
 reset values and counts. assumes a 16-bit register page with byte offsets.
*/
`ifndef BEC_DEFINES_SVH
`define BEC_DEFINES_SVH

`define BEC_OFS_INT_ENABLE   16'h010a
`define BEC_OFS_EVENT_FLAGS  16'h012c
`define BEC_OFS_LOST_COUNT   16'h0130
`define BEC_OFS_COL_COUNT    16'h0132

`define BEC_ID_INT_ENABLE    6'h0b
`define BEC_ID_EVENT_FLAGS   6'h0c
`define BEC_ID_LOST_COUNT    6'h10
`define BEC_ID_COL_COUNT     6'h12

`define BEC_RST_INT_ENABLE   16'h000b

`define BEC_BIT_SOFT         6
`define BEC_BIT_DMA_DONE     7
`define BEC_BIT_TX_ACCEPT    8
`define BEC_BIT_UNDERRUN     9
`define BEC_BIT_LOST_FRAME   10
`define BEC_BIT_EARLY_HDR    11
`define BEC_BIT_COL_HALF     12
`define BEC_BIT_LOST_HALF    13
`define BEC_BIT_ADDR_MATCH   15

`define BEC_ENABLE_WR_MASK   10'h2fe
`define BEC_EVENT_MASK       10'h23f
`define BEC_EARLY_HDR_BYTES  8'h80
`define BEC_COUNT_HALF       10'h200

`endif

// file: hdl/bec_pkg.sv
/*
 buffer event block types: event input bundle and receive header tracker states.
 assumes bec_defines.svh is included by the design files that need numbers.
*/
package bec_pkg;

    // events from mac, dma and filter logic on the same clock, one-cycle pulses
    typedef struct packed {
        logic dmaDone;
        logic txAccept;
        logic underrun;
        logic lostFrame;
        logic addrMatch;
        logic rxByte;
        logic rxEnd;
    } bec_evt_t;

    // gray coded along idle -> matched -> early
    typedef enum logic [1:0] {
        HDR_IDLE    = 2'h0,
        HDR_MATCHED = 2'h1,
        HDR_EARLY   = 2'h3
    } bec_hdr_state_t;

endpackage : bec_pkg

// file: hdl/bec_counter.sv
/*
 ten bit wrapping event counter with clear on read and half-way warning pulse.
 assumes inc and clr are single-cycle pulses on clk.
*/
`include "bec_defines.svh"

module bec_counter #(
    parameter int W = 10
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // control
    input  wire logic         inc,
    input  wire logic         clr,
    // status
    output logic [W-1:0]      count,
    output logic              halfStep
);

    logic [W-1:0] count_ff;
    logic         halfStep_ff;
    logic [W-1:0] nxt_count;

    // an increment in the read cycle is kept: the count restarts at one
    always_comb begin
        if (clr) begin
            nxt_count = inc ? W'(1) : '0;
        end else if (inc) begin
            nxt_count = count_ff + W'(1);
        end else begin
            nxt_count = count_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // pulse when the count steps from half minus one to half
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halfStep_ff <= 1'b0;
        end else begin
            halfStep_ff <= inc && !clr && (count_ff == W'(`BEC_COUNT_HALF - 1));
        end
    end

    assign count    = count_ff;
    assign halfStep = halfStep_ff;

endmodule : bec_counter

// file: hdl/bec_regs.sv
/*
 buffer interrupt enable, buffer event flags, lost frame and collision counters.
 assumes event inputs come from logic on clk; the collision pair is a raw pin level.
*/
// Our own choice: the plain strobed port.
`include "bec_defines.svh"

// Overview of operation
// R1 - each enable bit gates its event interrupt
// R2 - soft request write sets flag, interrupts once
// R3 - dma done sets bit 7
// R4 - transmit ready sets bit 8
// R5 - underrun sets bit 9, frame abandoned
// R6 - host reissues transmit request after underrun
// R7 - lost frame sets bit A, counts
// R8 - 128 bytes received sets bit B
// R9 - host keeps early enable off with dma
// R10 - address match sets bit F first
// R11 - at 128 bytes match becomes early
// R12 - event register read clears all flags
// R13 - event register id reads 001100
// R14 - lost count bits 6-F, wraps
// R15 - lost count 1FF to 200 warns
// R16 - lost count read returns and clears
// R17 - lost count id reads 010000
// R18 - collision during transmit increments count
// R19 - collision count 1FF to 200 warns
// R20 - enable reset 000b or eeprom value
// R21 - collision count read returns and clears
// R22 - collision count id reads 010010
// R23 - irq while any enabled event pends
module bec_regs (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // register port
    input  wire logic [15:0]       regAddr,
    input  wire logic [15:0]       regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [15:0]            regRdData,
    // events
    input  wire bec_pkg::bec_evt_t evt,
    input  wire logic              txActive,
    input  wire logic              collisionPair,
    // eeprom preload
    input  wire logic              eepromLoad,
    input  wire logic [15:0]       eepromData,
    // outputs
    output logic                   irq,
    output logic                   txAbandon
);

    logic [9:0]             enable_ff;
    logic [9:0]             flags_ff;
    logic [9:0]             nxt_flags;
    logic [9:0]             setFlags;
    logic [9:0]             clrFlags;
    logic [15:0]            regRdData_ff;
    logic                   irq_ff;
    logic                   txAbandon_ff;
    logic                   colWarn_ff;
    logic                   lostWarn_ff;
    logic                   col1_ff;
    logic                   col2_ff;
    logic                   col3_ff;
    logic                   colLevel_ff;
    logic                   colRise;
    logic [7:0]             byteCnt_ff;
    bec_pkg::bec_hdr_state_t hdrState_ff;
    logic                   earlyHit;
    logic                   wrEnable;
    logic                   rdEvent;
    logic                   rdLost;
    logic                   rdCol;
    logic [9:0]             lostCount;
    logic [9:0]             collision_count;
    logic                   lostHalf;
    logic                   colHalf;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic en(input logic [9:0] e, input int b);
        en = e[b-6];
    endfunction : en

    assign wrEnable = regWr && hit(regAddr, `BEC_OFS_INT_ENABLE);
    assign rdEvent  = regRd && hit(regAddr, `BEC_OFS_EVENT_FLAGS);
    assign rdLost   = regRd && hit(regAddr, `BEC_OFS_LOST_COUNT);
    assign rdCol    = regRd && hit(regAddr, `BEC_OFS_COL_COUNT);

    // enable register; the soft request bit is never stored so it reads zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_ff <= 10'(`BEC_RST_INT_ENABLE >> 6); // R20
        end else if (eepromLoad) begin
            enable_ff <= eepromData[15:6] & `BEC_ENABLE_WR_MASK; // R20
        end else if (wrEnable) begin
            enable_ff <= regWrData[15:6] & `BEC_ENABLE_WR_MASK;
        end
    end

    // collision pair: three stages, a rise counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            col1_ff     <= 1'b0;
            col2_ff     <= 1'b0;
            col3_ff     <= 1'b0;
            colLevel_ff <= 1'b0;
        end else begin
            col1_ff <= collisionPair;
            col2_ff <= col1_ff;
            col3_ff <= col2_ff;
            if (col2_ff == col3_ff) begin
                colLevel_ff <= col3_ff;
            end
        end
    end

    assign colRise = col2_ff && col3_ff && !colLevel_ff && txActive; // R18

    // early header tracker: address match first, early header at 128 bytes
    assign earlyHit = (hdrState_ff == bec_pkg::HDR_MATCHED) && evt.rxByte
                      && (byteCnt_ff == `BEC_EARLY_HDR_BYTES - 8'h01);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hdrState_ff <= bec_pkg::HDR_IDLE;
            byteCnt_ff  <= 8'h00;
        end else begin
            case (hdrState_ff)
                bec_pkg::HDR_IDLE: begin
                    byteCnt_ff <= 8'h00;
                    if (evt.addrMatch && !evt.rxEnd) begin
                        hdrState_ff <= bec_pkg::HDR_MATCHED; // R10
                    end
                end
                bec_pkg::HDR_MATCHED: begin
                    if (evt.rxEnd) begin
                        hdrState_ff <= bec_pkg::HDR_IDLE;
                    end else if (earlyHit) begin
                        hdrState_ff <= bec_pkg::HDR_EARLY; // R8
                    end else if (evt.rxByte) begin
                        byteCnt_ff <= byteCnt_ff + 8'h01;
                    end
                end
                bec_pkg::HDR_EARLY: begin
                    if (evt.rxEnd) begin
                        hdrState_ff <= bec_pkg::HDR_IDLE;
                    end
                end
                default: begin
                    hdrState_ff <= bec_pkg::HDR_IDLE;
                end
            endcase
        end
    end

    // event flags; a set in the read cycle survives the clear
    always_comb begin
        setFlags = '0;
        setFlags[`BEC_BIT_SOFT - 6]       = wrEnable && regWrData[`BEC_BIT_SOFT]; // R2
        setFlags[`BEC_BIT_DMA_DONE - 6]   = evt.dmaDone; // R3
        setFlags[`BEC_BIT_TX_ACCEPT - 6]  = evt.txAccept; // R4
        setFlags[`BEC_BIT_UNDERRUN - 6]   = evt.underrun; // R5
        setFlags[`BEC_BIT_LOST_FRAME - 6] = evt.lostFrame; // R7
        setFlags[`BEC_BIT_EARLY_HDR - 6]  = earlyHit; // R8
        setFlags[`BEC_BIT_ADDR_MATCH - 6] = evt.addrMatch && hdrState_ff == bec_pkg::HDR_IDLE;
        clrFlags = rdEvent ? `BEC_EVENT_MASK : 10'h000; // R12
        // the reported event moves from address match to early header
        if (earlyHit && en(enable_ff, `BEC_BIT_ADDR_MATCH)) begin
            clrFlags[`BEC_BIT_ADDR_MATCH - 6] = 1'b1; // R11
        end
        nxt_flags = ((flags_ff & ~clrFlags) | setFlags) & `BEC_EVENT_MASK;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    bec_counter #(
        .W (10)
    ) u_lost (
        .clk      (clk),
        .rst_b    (rst_b),
        .inc      (evt.lostFrame), // R7
        .clr      (rdLost), // R16
        .count    (lostCount), // R14
        .halfStep (lostHalf)
    );

    bec_counter #(
        .W (10)
    ) u_col (
        .clk      (clk),
        .rst_b    (rst_b),
        .inc      (colRise), // R18
        .clr      (rdCol), // R21
        .count    (collision_count),
        .halfStep (colHalf)
    );

    // half-way warnings stay pending until the matching counter is read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lostWarn_ff <= 1'b0;
            colWarn_ff  <= 1'b0;
        end else begin
            lostWarn_ff <= lostHalf || (lostWarn_ff && !rdLost); // R15
            colWarn_ff  <= colHalf || (colWarn_ff && !rdCol); // R19
        end
    end

    // interrupt: soft flag always, others through their enables
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_flags & (enable_ff | 10'h001)) // R1 R23
                      || (lostWarn_ff && en(enable_ff, `BEC_BIT_LOST_HALF)) // R15
                      || (colWarn_ff && en(enable_ff, `BEC_BIT_COL_HALF)); // R19
        end
    end

    // the frame engine drops the underrun frame; no retry is attempted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txAbandon_ff <= 1'b0;
        end else begin
            txAbandon_ff <= evt.underrun; // R5
        end
    end

    // read data one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData_ff <= 16'h0000;
        end else if (!regRd) begin
            regRdData_ff <= 16'h0000;
        end else if (hit(regAddr, `BEC_OFS_INT_ENABLE)) begin
            regRdData_ff <= {enable_ff, `BEC_ID_INT_ENABLE};
        end else if (hit(regAddr, `BEC_OFS_EVENT_FLAGS)) begin
            regRdData_ff <= {flags_ff, `BEC_ID_EVENT_FLAGS}; // R12 R13
        end else if (hit(regAddr, `BEC_OFS_LOST_COUNT)) begin
            regRdData_ff <= {lostCount, `BEC_ID_LOST_COUNT}; // R16 R17
        end else if (hit(regAddr, `BEC_OFS_COL_COUNT)) begin
            regRdData_ff <= {collision_count, `BEC_ID_COL_COUNT}; // R21 R22
        end else begin
            regRdData_ff <= 16'h0000;
        end
    end

    assign regRdData = regRdData_ff;
    assign irq       = irq_ff;
    assign txAbandon = txAbandon_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_softWrite;
        regWr && regAddr == `BEC_OFS_INT_ENABLE && regWrData[`BEC_BIT_SOFT];
    endsequence

    sequence s_softSeen;
        flags_ff[0] && irq_ff;
    endsequence

    property p_soft_irq;
        s_softWrite |=> s_softSeen;
    endproperty
    a_soft_irq: assert property (p_soft_irq) else $error("soft request gave no irq"); // R2

    property p_masked_quiet;
        (enable_ff == 10'h000 && flags_ff[0] == 1'b0 && !regWr) |=> !irq_ff;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("irq with all masked"); // R1

    property p_dma_flag;
        evt.dmaDone |=> flags_ff[1];
    endproperty
    a_dma_flag: assert property (p_dma_flag) else $error("dma done flag missing"); // R3

    property p_tx_accept;
        evt.txAccept |=> flags_ff[2];
    endproperty
    a_tx_accept: assert property (p_tx_accept) else $error("tx accept flag missing"); // R4

    property p_match_flag;
        (evt.addrMatch && hdrState_ff == bec_pkg::HDR_IDLE) |=> flags_ff[9];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("address match flag missing"); // R10

    property p_underrun;
        evt.underrun |=> flags_ff[3] && txAbandon_ff;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not handled"); // R5

    property p_read_clear;
        (rdEvent && !evt.dmaDone && !evt.txAccept) |=> !flags_ff[1] && !flags_ff[2];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("event read kept flags"); // R12

    property p_event_id;
        rdEvent |=> regRdData_ff[5:0] == 6'h0c;
    endproperty
    a_event_id: assert property (p_event_id) else $error("event id wrong"); // R13

    property p_lost_id;
        rdLost |=> regRdData_ff[5:0] == 6'h10 ##1 (regRdData_ff == 16'h0000 || $past(regRd));
    endproperty
    a_lost_id: assert property (p_lost_id) else $error("lost id or hold wrong"); // R17

    property p_col_id;
        rdCol |=> regRdData_ff[5:0] == 6'h12;
    endproperty
    a_col_id: assert property (p_col_id) else $error("collision id wrong"); // R22

    property p_lost_clear;
        (rdLost && !evt.lostFrame) |=> lostCount == 10'h000;
    endproperty
    a_lost_clear: assert property (p_lost_clear) else $error("lost count not cleared"); // R16

    property p_lost_inc;
        (evt.lostFrame && !rdLost) |=> lostCount == $past(lostCount) + 10'h001;
    endproperty
    a_lost_inc: assert property (p_lost_inc) else $error("lost count not stepped"); // R7

    property p_col_inc;
        (colRise && !rdCol) |=> collision_count == $past(collision_count) + 10'h001;
    endproperty
    a_col_inc: assert property (p_col_inc) else $error("collision count not stepped"); // R18

    // warning pulse, then one cycle for the pending bit, then the irq flop
    sequence s_lostHalfArmed;
        (lostHalf && enable_ff[7]) ##1 enable_ff[7];
    endsequence

    property p_lost_warn;
        s_lostHalfArmed |=> irq_ff;
    endproperty
    a_lost_warn: assert property (p_lost_warn) else $error("lost half warning gave no irq"); // R15

    sequence s_colHalfArmed;
        (colHalf && enable_ff[6]) ##1 enable_ff[6];
    endsequence

    property p_col_warn;
        s_colHalfArmed |=> irq_ff;
    endproperty
    a_col_warn: assert property (p_col_warn) else $error("collision half warning gave no irq"); // R19

    property p_early_swap;
        (earlyHit && enable_ff[9] && !evt.addrMatch) |=> flags_ff[5] && !flags_ff[9];
    endproperty
    a_early_swap: assert property (p_early_swap) else $error("early header swap wrong"); // R11

endmodule : bec_regs

// file: verification/bec_host_model.sv
/*
 host processor model: bus master on the register port of the buffer event block.
 assumes read data stand only in the cycle after the read strobe.
*/
module bec_host_model (
    // clock
    input  wire logic        clk,
    // register port
    output logic [15:0]      regAddr,
    output logic [15:0]      regWrData,
    output logic             regWr,
    output logic             regRd,
    input  wire logic [15:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        regAddr   = '0;
        regWrData = '0;
        regWr     = 1'b0;
        regRd     = 1'b0;
    end

    // strobe drops on the next edge, so a following call never doubles a strobe
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask : wr

    // data taken at the edge that closes the one cycle in which they stand
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        @(posedge clk);
        d = regRdData;
    endtask : rd
endmodule : bec_host_model

// file: verification/bec_regs_tb.sv
/*
 self-checking bench for the buffer event block: registers, events, counters.
 assumes the host model as bus master and event pulses driven here on clk.
*/
`include "bec_defines.svh"

module bec_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] EN = `BEC_OFS_INT_ENABLE;
    localparam logic [15:0] EV = `BEC_OFS_EVENT_FLAGS;
    localparam logic [15:0] LC = `BEC_OFS_LOST_COUNT;
    localparam logic [15:0] CC = `BEC_OFS_COL_COUNT;

    logic              clk           = 1'b0;
    logic              rst_b         = 1'b0;
    logic [15:0]       regAddr;
    logic [15:0]       regWrData;
    logic              regWr;
    logic              regRd;
    logic [15:0]       regRdData;
    bec_pkg::bec_evt_t evt           = '0;
    logic              txActive      = 1'b0;
    logic              collisionPair = 1'b0;
    logic              eepromLoad    = 1'b0;
    logic [15:0]       eepromData    = '0;
    logic              irq;
    logic              txAbandon;
    logic [15:0]       rdVal;
    logic              abandonSeen;
    int                badCount      = 0;
    int                checksDone    = 0;

    always #12.5 clk = ~clk;

    bec_host_model host_i (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
                           .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

    bec_regs bec_regs_i (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
                         .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
                         .regRdData(regRdData), .evt(evt), .txActive(txActive),
                         .collisionPair(collisionPair), .eepromLoad(eepromLoad),
                         .eepromData(eepromData), .irq(irq), .txAbandon(txAbandon));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
        host_i.rd(a, rdVal);
        chk(what, exp, rdVal);
    endtask : rd_chk

    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        evt <= bec_pkg::bec_evt_t'(v);
        @(posedge clk);
        evt <= '0;
        #1 abandonSeen = txAbandon;
    endtask : pulse

    // bounded wait; a level that never comes ends the run
    task automatic irq_is(input logic exp);
        int i;
        repeat (3) @(posedge clk);
        for (i = 0; i < 6 && irq !== exp; i++)
            @(posedge clk);
        chk("irq", {15'h0, exp}, {15'h0, irq});
        if (irq !== exp)
            close_out();
    endtask : irq_is

    // pin held high 4 cycles and low at least 4 so the synchroniser sees every edge
    task automatic collide(input int n);
        repeat (n) begin
            @(posedge clk);
            collisionPair <= 1'b1;
            repeat (4) @(posedge clk);
            collisionPair <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : collide

    initial begin : main
        int i;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("enable", EN, `BEC_RST_INT_ENABLE);
        rd_chk("flags", EV, {10'h0, `BEC_ID_EVENT_FLAGS});
        rd_chk("lost", LC, {10'h0, `BEC_ID_LOST_COUNT});
        rd_chk("col", CC, {10'h0, `BEC_ID_COL_COUNT});
        rd_chk("unmapped", 16'h0134, 16'h0000);
        host_i.wr(EV, 16'hffc0);
        rd_chk("flags ro", EV, 16'h000c);
        host_i.wr(EN, 16'h0040);
        irq_is(1'b1);
        rd_chk("flags soft", EV, 16'h004c);
        irq_is(1'b0);
        rd_chk("flags clear", EV, 16'h000c);
        rd_chk("soft reads 0", EN, 16'h000b);
        for (i = 0; i < 4; i++) begin
            host_i.wr(EN, 16'h0080 << i);
            pulse(7'h40 >> i);
            chk("txAbandon", {15'h0, i == 2}, {15'h0, abandonSeen});
            irq_is(1'b1);
            rd_chk("flag on", EV, (16'h0080 << i) | 16'h000c);
            irq_is(1'b0);
            host_i.wr(EN, 16'h0000);
            pulse(7'h40 >> i);
            irq_is(1'b0);
            rd_chk("flag off", EV, (16'h0080 << i) | 16'h000c);
        end
        rd_chk("lost two", LC, 16'h0090);
        rd_chk("lost cleared", LC, 16'h0010);
        // early header enable is switched on below: no receive dma is modelled here
        host_i.wr(EN, 16'h8000);
        pulse(7'h04);
        irq_is(1'b1);
        for (i = 0; i < 128; i++)
            pulse(7'h02);
        irq_is(1'b0);
        rd_chk("match to early", EV, 16'h080c);
        pulse(7'h01);
        host_i.wr(EN, 16'h0800);
        pulse(7'h04);
        for (i = 0; i < 127; i++)
            pulse(7'h02);
        irq_is(1'b0);
        rd_chk("match first", EV, 16'h800c);
        pulse(7'h02);
        irq_is(1'b1);
        rd_chk("early", EV, 16'h080c);
        pulse(7'h01);
        host_i.wr(EN, 16'h2000);
        for (i = 0; i < 511; i++)
            pulse(7'h08);
        irq_is(1'b0);
        pulse(7'h08);
        irq_is(1'b1);
        rd_chk("lost half", LC, 16'h8010);
        irq_is(1'b0);
        for (i = 0; i < 1024; i++)
            pulse(7'h08);
        rd_chk("lost wrap", LC, 16'h0010);
        rd_chk("flags lost", EV, 16'h040c);
        host_i.wr(EN, 16'h1000);
        collide(2);
        rd_chk("col idle", CC, 16'h0012);
        txActive <= 1'b1;
        collide(511);
        irq_is(1'b0);
        collide(1);
        irq_is(1'b1);
        rd_chk("col half", CC, 16'h8012);
        irq_is(1'b0);
        collide(3);
        rd_chk("col three", CC, 16'h00d2);
        @(posedge clk);
        eepromData <= 16'h2a80;
        eepromLoad <= 1'b1;
        @(posedge clk);
        eepromLoad <= 1'b0;
        rd_chk("eeprom", EN, 16'h2a8b);
        host_i.wr(EN, 16'hffbf);
        rd_chk("enable mask", EN, 16'hbf8b);
        close_out();
    end
endmodule : bec_regs_tb
